// ### design/five_bit_dac_defs.vh
// register map, field positions and reset values of the 5-bit converter group
`ifndef FIVE_BIT_DAC_DEFS_VH
`define FIVE_BIT_DAC_DEFS_VH

`define ADDR_W 4
`define DATA_W 8
`define NUM_INST 3
`define CODE_W 5
// address layout: instance index in bits 3:1, register select in bit 0
`define SEL_CONTROL 1'h0
`define SEL_LEVEL 1'h1
`define ENABLE_BIT 7
`define PIN_ONE_BIT 5
`define PIN_TWO_BIT 4
`define PSS_HI 3
`define PSS_LO 2
`define NSS_HI 1
`define NSS_LO 0
// bits of the control register that hold storage
`define CONTROL_MASK 8'hBF
`define LEVEL_MASK 8'h1F
`define CONTROL_RESET 8'h00
`define LEVEL_RESET 8'h00
`define ZERO_BYTE 8'h00
// source select encodings
`define SRC_SEL_0 2'h0
`define SRC_SEL_1 2'h1
`define SRC_SEL_2 2'h2
`define SRC_SEL_3 2'h3
// one-hot positive source codes
`define POS_SUPPLY 3'h1
`define POS_REF_PIN 3'h2
`define POS_FIXED_REF 3'h4
`define POS_NONE 3'h0
// one-hot negative source codes
`define NEG_GROUND 3'h1
`define NEG_FIRST_PIN 3'h2
`define NEG_SECOND_PIN 3'h4
`define NEG_NONE 3'h0
// instance that owns the second negative reference pin
`define SECOND_NEG_INST 2

`endif

// ### design/five_bit_dac_control.v
// control logic for three 5-bit voltage-reference converters
// Function
// R01 - Each converter runs only while bit 7 of its control register is one, and clearing it disables it.
// R02 - Each converter offers 32 levels chosen by a 5-bit code in the low five bits of the level register.
// R03 - The level reaches comparators, op amps and the ADC channel regardless of the pin enables.
// R04 - Control bit 5 puts the level on the first output pin and bit 4 on the second; clear bits disconnect.
// R05 - A pin carrying the level has its digital driver and input threshold detector turned off.
// R06 - A digital read of a pin carrying the level returns 0.
// R07 - The converter keeps its level and routing during Sleep.
// R08 - Waking from Sleep by interrupt or watchdog leaves the control register unchanged.
// R09 - Any device reset clears both registers, disabling the converter and freeing the pins.
// R10 - Positive source select bits 3-2 decode 00 supply, 01 reference pin, 10 fixed reference; 11 is not used.
// R11 - Negative source select bits 1-0 decode 00 ground, 01 first pin, 10 second pin on instance three only.
// R12 - Control bit 6 is not stored and reads as zero.
// R13 - Level register bits 7-5 are not stored and read as zero.
// R14 - There are three independent instances, each with its own identical pair of registers.
// R15 - Writes take effect in the next cycle with no double buffering, and reads return stored bits.
`timescale 1ns/100ps
`include "five_bit_dac_defs.vh"

module five_bit_dac_control #(
    parameter NUM_INST = `NUM_INST,
    parameter CODE_W = `CODE_W
) (
    input wire clk_in,
    input wire srst_in,
    input wire sleep_in,
    input wire [`ADDR_W-1:0] addr_in,
    input wire [`DATA_W-1:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire [NUM_INST-1:0] first_pin_digital_in,
    input wire [NUM_INST-1:0] second_pin_digital_in,
    output reg [`DATA_W-1:0] rdata_out,
    output reg [NUM_INST-1:0] converter_active_out,
    output reg [NUM_INST*CODE_W-1:0] ladder_tap_out,
    output reg [NUM_INST*CODE_W-1:0] internal_level_out,
    output reg [NUM_INST*3-1:0] positive_source_select_out,
    output reg [NUM_INST*3-1:0] negative_source_select_out,
    output reg [NUM_INST-1:0] first_pin_analog_out,
    output reg [NUM_INST-1:0] second_pin_analog_out,
    output reg [NUM_INST-1:0] first_pin_digital_oe_n_out,
    output reg [NUM_INST-1:0] second_pin_digital_oe_n_out,
    output reg [NUM_INST-1:0] first_pin_threshold_en_out,
    output reg [NUM_INST-1:0] second_pin_threshold_en_out,
    output reg [NUM_INST-1:0] first_pin_read_out,
    output reg [NUM_INST-1:0] second_pin_read_out
);

    // decode of the positive source field into a one-hot code
    function [2:0] pos_decode;
        input [1:0] sel;
        begin
            case (sel)
                `SRC_SEL_0: pos_decode = `POS_SUPPLY;
                `SRC_SEL_1: pos_decode = `POS_REF_PIN;
                `SRC_SEL_2: pos_decode = `POS_FIXED_REF;
                default: pos_decode = `POS_NONE;
            endcase
        end
    endfunction

    // decode of the negative source field; second pin exists on one instance only
    function [2:0] neg_decode;
        input [1:0] sel;
        input has_second;
        begin
            case (sel)
                `SRC_SEL_0: neg_decode = `NEG_GROUND;
                `SRC_SEL_1: neg_decode = `NEG_FIRST_PIN;
                `SRC_SEL_2: neg_decode = has_second ? `NEG_SECOND_PIN : `NEG_NONE;
                default: neg_decode = `NEG_NONE;
            endcase
        end
    endfunction

    wire [`ADDR_W-2:0] inst_sel;
    wire reg_sel;
    reg [`DATA_W-1:0] read_mux;
    integer k;

    // register storage, one pair per instance
    reg [`DATA_W-1:0] dac_control_reg [0:NUM_INST-1];
    reg [`DATA_W-1:0] dac_level_select_reg [0:NUM_INST-1];

    assign inst_sel = addr_in[`ADDR_W-1:1];
    assign reg_sel = addr_in[0];

    genvar i;
    generate
        for (i = 0; i < NUM_INST; i = i + 1) begin : inst
            // instance index at the width of inst_sel, one bit narrower than the address, since a genvar takes no part-select
            localparam [`ADDR_W-2:0] IDX = i;
            wire hit;
            wire [`DATA_W-1:0] ctl;
            wire [`DATA_W-1:0] lvl;
            wire en;
            wire oe1;
            wire oe2;
            assign hit = wr_in && (inst_sel == IDX); // see R14
            assign ctl = dac_control_reg[i];
            assign lvl = dac_level_select_reg[i];
            assign en = ctl[`ENABLE_BIT];
            assign oe1 = ctl[`PIN_ONE_BIT];
            assign oe2 = ctl[`PIN_TWO_BIT];

            // register writes; sleep_in does not touch storage
            always @(posedge clk_in) begin
                if (srst_in) begin
                    dac_control_reg[i] <= `CONTROL_RESET; // see R09
                    dac_level_select_reg[i] <= `LEVEL_RESET; // see R09
                end else if (hit && reg_sel == `SEL_CONTROL) begin
                    dac_control_reg[i] <= wdata_in & `CONTROL_MASK; // see R12 see R15 see R08
                end else if (hit && reg_sel == `SEL_LEVEL) begin
                    dac_level_select_reg[i] <= wdata_in & `LEVEL_MASK; // see R13 see R02
                end
            end

            // analog side controls, kept alive in sleep
            always @(posedge clk_in) begin
                if (srst_in) begin
                    converter_active_out[i] <= 1'b0;
                    ladder_tap_out[i*CODE_W +: CODE_W] <= {CODE_W{1'b0}};
                    internal_level_out[i*CODE_W +: CODE_W] <= {CODE_W{1'b0}};
                    positive_source_select_out[i*3 +: 3] <= `POS_NONE;
                    negative_source_select_out[i*3 +: 3] <= `NEG_NONE;
                    first_pin_analog_out[i] <= 1'b0;
                    second_pin_analog_out[i] <= 1'b0;
                    first_pin_digital_oe_n_out[i] <= 1'b1;
                    second_pin_digital_oe_n_out[i] <= 1'b1;
                    first_pin_threshold_en_out[i] <= 1'b1;
                    second_pin_threshold_en_out[i] <= 1'b1;
                    first_pin_read_out[i] <= 1'b0;
                    second_pin_read_out[i] <= 1'b0;
                end else begin
                    converter_active_out[i] <= en; // see R01 see R07
                    ladder_tap_out[i*CODE_W +: CODE_W] <= lvl[CODE_W-1:0]; // see R02
                    // internal route follows enable only, not the pin bits
                    internal_level_out[i*CODE_W +: CODE_W] <= en ? lvl[CODE_W-1:0] : {CODE_W{1'b0}}; // see R03
                    positive_source_select_out[i*3 +: 3] <= pos_decode(ctl[`PSS_HI:`PSS_LO]); // see R10
                    negative_source_select_out[i*3 +: 3] <=
                        neg_decode(ctl[`NSS_HI:`NSS_LO], i == `SECOND_NEG_INST); // see R11
                    first_pin_analog_out[i] <= oe1; // see R04
                    second_pin_analog_out[i] <= oe2; // see R04
                    // pin digital driver held off (enable high) at all times, whether or not analog drives
                    first_pin_digital_oe_n_out[i] <= 1'b1; // see R05
                    second_pin_digital_oe_n_out[i] <= 1'b1; // see R05
                    first_pin_threshold_en_out[i] <= ~oe1; // see R05
                    second_pin_threshold_en_out[i] <= ~oe2; // see R05
                    first_pin_read_out[i] <= oe1 ? 1'b0 : first_pin_digital_in[i]; // see R06
                    second_pin_read_out[i] <= oe2 ? 1'b0 : second_pin_digital_in[i]; // see R06
                end
            end
        end
    endgenerate

    // read decode; unmapped addresses read zero
    always @* begin
        read_mux = `ZERO_BYTE;
        for (k = 0; k < NUM_INST; k = k + 1) begin
            if (inst_sel == k[`ADDR_W-2:0]) begin
                if (reg_sel == `SEL_CONTROL) begin
                    read_mux = dac_control_reg[k] & `CONTROL_MASK; // see R12
                end else begin
                    read_mux = dac_level_select_reg[k] & `LEVEL_MASK; // see R13
                end
            end
        end
    end

    // read data registered, valid the cycle after the strobe
    always @(posedge clk_in) begin
        if (srst_in) begin
            rdata_out <= `ZERO_BYTE;
        end else if (rd_in) begin
            rdata_out <= read_mux; // see R15
        end else begin
            rdata_out <= `ZERO_BYTE;
        end
    end

endmodule

// ### tb/five_bit_dac_control_asserts.sv
// port checker for the converter group control
`timescale 1ns/100ps
module five_bit_dac_control_asserts #(
    parameter NUM_INST = 3,
    parameter CODE_W = 5
) (
    input wire clk_in,
    input wire srst_in,
    input wire [3:0] addr_in,
    input wire [7:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire [7:0] rdata_out,
    input wire [NUM_INST-1:0] converter_active_out,
    input wire [NUM_INST*CODE_W-1:0] ladder_tap_out,
    input wire [NUM_INST*CODE_W-1:0] internal_level_out,
    input wire [NUM_INST*3-1:0] positive_source_select_out,
    input wire [NUM_INST*3-1:0] negative_source_select_out,
    input wire [NUM_INST-1:0] first_pin_analog_out,
    input wire [NUM_INST-1:0] second_pin_analog_out,
    input wire [NUM_INST-1:0] first_pin_threshold_en_out,
    input wire [NUM_INST-1:0] first_pin_read_out
);
    // all checks on the system clock
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);
    property p_rd_idle; !$past(rd_in) |-> rdata_out == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_unimpl; $past(rd_in) |-> !rdata_out[6] && !($past(addr_in[0]) && |rdata_out[7:5]); endproperty
    a_unimpl: assert property (p_unimpl) else $error("unused bits read set");
    property p_enable; wr_in && addr_in == 4'h0 |-> ##2 converter_active_out[0] == $past(wdata_in[7], 2); endproperty
    a_enable: assert property (p_enable) else $error("enable wrong");
    property p_pins; wr_in && addr_in == 4'h0 |-> ##2 {first_pin_analog_out[0], second_pin_analog_out[0]} == $past(wdata_in[5:4], 2); endproperty
    a_pins: assert property (p_pins) else $error("pin routing wrong");
    property p_pos; wr_in && addr_in == 4'h0 |-> ##2 positive_source_select_out[2:0] == (($past(wdata_in[3:2], 2) == 2'h3) ? 3'h0 : 3'h1 << $past(wdata_in[3:2], 2)); endproperty
    a_pos: assert property (p_pos) else $error("positive select wrong");
    property p_neg; wr_in && addr_in == 4'h4 |-> ##2 negative_source_select_out[8:6] == (($past(wdata_in[1:0], 2) == 2'h3) ? 3'h0 : 3'h1 << $past(wdata_in[1:0], 2)); endproperty
    a_neg: assert property (p_neg) else $error("negative select wrong");
    property p_level; wr_in && addr_in == 4'h1 |-> ##2 ladder_tap_out[4:0] == $past(wdata_in[4:0], 2); endproperty
    a_level: assert property (p_level) else $error("ladder tap wrong");
    property p_internal; internal_level_out[4:0] == (converter_active_out[0] ? ladder_tap_out[4:0] : 5'h00); endproperty
    a_internal: assert property (p_internal) else $error("internal level wrong");
    property p_pin_read; (first_pin_read_out & first_pin_analog_out) == 3'h0 && first_pin_threshold_en_out == ~first_pin_analog_out; endproperty
    a_pin_read: assert property (p_pin_read) else $error("pin digital path wrong");
    property p_hold; !wr_in && !$past(wr_in) |=> $stable(converter_active_out) && $stable(ladder_tap_out); endproperty
    a_hold: assert property (p_hold) else $error("state moved without write");
endmodule
bind five_bit_dac_control five_bit_dac_control_asserts #(.NUM_INST(NUM_INST), .CODE_W(CODE_W)) i_five_bit_dac_control_asserts (
    .clk_in, .srst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .converter_active_out, .ladder_tap_out,
    .internal_level_out, .positive_source_select_out, .negative_source_select_out, .first_pin_analog_out,
    .second_pin_analog_out, .first_pin_threshold_en_out, .first_pin_read_out);

// ### tb/five_bit_dac_control_tb_top.sv
// self-checking bench for the converter group control
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end
module five_bit_dac_control_tb_top;
    reg clk_in = 1'b0;
    reg srst_in = 1'b1;
    reg sleep_in = 1'b0;
    reg [3:0] addr_in = 4'h0;
    reg [7:0] wdata_in = 8'h00;
    reg wr_in = 1'b0;
    reg rd_in = 1'b0;
    reg [2:0] pin_one_in = 3'h7;
    reg [2:0] pin_two_in = 3'h5;
    wire [7:0] rdata_out;
    wire [2:0] active, ana_one, ana_two, oe_one, oe_two, thr_one, thr_two, rd_one, rd_two;
    wire [14:0] tap, lvl;
    wire [8:0] pos, neg;
    integer failures = 0;
    integer n_checks = 0;
    five_bit_dac_control i_five_bit_dac_control (.clk_in(clk_in), .srst_in(srst_in), .sleep_in(sleep_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .first_pin_digital_in(pin_one_in),
        .second_pin_digital_in(pin_two_in), .rdata_out(rdata_out), .converter_active_out(active),
        .ladder_tap_out(tap), .internal_level_out(lvl), .positive_source_select_out(pos),
        .negative_source_select_out(neg), .first_pin_analog_out(ana_one), .second_pin_analog_out(ana_two),
        .first_pin_digital_oe_n_out(oe_one), .second_pin_digital_oe_n_out(oe_two),
        .first_pin_threshold_en_out(thr_one), .second_pin_threshold_en_out(thr_two),
        .first_pin_read_out(rd_one), .second_pin_read_out(rd_two));
    // 40 MHz clock
    initial begin
        forever #12.5 clk_in = ~clk_in;
    end
    // one bus cycle launched after a rising edge
    task bus(input w, input r, input [3:0] a, input [7:0] d);
        begin
            @(posedge clk_in);
            wr_in <= w;
            rd_in <= r;
            addr_in <= a;
            wdata_in <= d;
        end
    endtask
    // read strobe, then compare data in the following cycle
    task rd(input [3:0] a, input [7:0] e);
        begin
            bus(1'b0, 1'b1, a, 8'h00);
            bus(1'b0, 1'b0, a, 8'h00);
            #1;
            `CHK("rdata", e, rdata_out)
        end
    endtask
    task t_reset;
        integer i;
        begin
            for (i = 0; i < 6; i++) rd(4'(i), 8'h00);
            `CHK("oe_n", 6'h3F, {oe_one, oe_two})
            `CHK("threshold", 6'h3F, {thr_one, thr_two})
        end
    endtask
    // every legal source code on every instance, write then read back to back
    task t_control;
        integer p;
        integer i;
        reg [1:0] s;
        reg [7:0] d;
        begin
            for (p = 0; p < 9; p++) begin
                i = p % 3;
                s = 2'((p + p / 3) % 3);
                d = {2'h3, p[0], ~p[0], s, s};
                bus(1'b1, 1'b0, 4'(i * 2), d);
                rd(4'(i * 2), d & 8'hBF);
                `CHK("active", 1'b1, active[i])
                `CHK("pins", {p[0], ~p[0]}, {ana_one[i], ana_two[i]})
                `CHK("positive", (s == 2'h3) ? 3'h0 : 3'h1 << s, pos[i*3 +: 3])
                `CHK("negative", (s == 2'h3 || (s == 2'h2 && i != 2)) ? 3'h0 : 3'h1 << s, neg[i*3 +: 3])
            end
            rd(4'h4, 8'h95);
            bus(1'b1, 1'b0, 4'hE, 8'hFF);
            rd(4'hE, 8'h00);
        end
    endtask
    task t_level;
        begin
            bus(1'b1, 1'b0, 4'h0, 8'hA0);
            bus(1'b1, 1'b0, 4'h1, 8'hFF);
            rd(4'h1, 8'h1F);
            `CHK("tap", 5'h1F, tap[4:0])
            `CHK("internal", 5'h1F, lvl[4:0])
            `CHK("pin read", 2'h0, {rd_one[0], thr_one[0]})
            `CHK("pin two read", 2'h3, {rd_two[0], thr_two[0]})
            bus(1'b1, 1'b0, 4'h0, 8'h00);
            rd(4'h0, 8'h00);
            `CHK("internal off", 5'h00, lvl[4:0])
            `CHK("pin read off", 2'h3, {rd_one[0], thr_one[0]})
        end
    endtask
    task t_sleep_reset;
        begin
            @(posedge clk_in);
            sleep_in <= 1'b1;
            repeat (8) @(posedge clk_in);
            rd(4'h4, 8'h95);
            `CHK("sleep tap", 5'h1F, tap[4:0])
            @(posedge clk_in);
            sleep_in <= 1'b0;
            srst_in <= 1'b1;
            repeat (4) @(posedge clk_in);
            srst_in <= 1'b0;
            t_reset;
            `CHK("cleared", 9'h000, {active, ana_one, ana_two})
        end
    endtask
    task report_and_stop;
        begin
            $display("checks %0d failures %0d", n_checks, failures);
            if (failures == 0 && n_checks > 0) begin
                $display("All tests passed");
            end else begin
                $display("Some tests failed");
            end
            $finish;
        end
    endtask
    // main sequence after four reset cycles
    initial begin
        repeat (4) @(posedge clk_in);
        srst_in <= 1'b0;
        t_reset;
        t_control;
        t_level;
        t_sleep_reset;
        report_and_stop;
    end
    // watchdog, several times the expected run of about 85 cycles
    initial begin
        #20000;
        failures = failures + 1;
        report_and_stop;
    end
endmodule
